/* shared/epw_map.vh */
// Register offsets, field layout and reset values of the eight-bit port.
`ifndef EPW_MAP_VH
`define EPW_MAP_VH

`define EPW_ADDR_W          16
`define EPW_DATA_W          8
`define EPW_ADDR_FUNC_SEL   16'hff9b
`define EPW_ADDR_PULLUP     16'hff9e
`define EPW_ADDR_DATA       16'hffd8
`define EPW_ADDR_DIR        16'hffe8
`define EPW_ADDR_MODE       16'hff00
`define EPW_RESET_VAL       8'h00
`define EPW_DIR_READ_VAL    8'hff
`define EPW_UNMAPPED_VAL    8'h00
`define EPW_PIN_IDLE        1'b0
`define EPW_MODE_W          3
`define EPW_MODE_ACTIVE     3'h0
`define EPW_MODE_SLEEP      3'h1
`define EPW_MODE_SUBSLEEP   3'h2
`define EPW_MODE_STANDBY    3'h3
`define EPW_MODE_WATCH      3'h4
`define EPW_MODE_SUBACTIVE  3'h5

`endif

/* hw/epw_sync.v */
// Three-stage input synchroniser with change accepted when the last two stages agree.
`timescale 1ns/1ps
`default_nettype none

module epw_sync #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] s1_reg;
	reg [WIDTH-1:0] s2_reg;
	reg [WIDTH-1:0] s3_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_reg[i] <= 1'b0;
					s2_reg[i] <= 1'b0;
					s3_reg[i] <= 1'b0;
					dout[i]   <= 1'b0;
				end else begin
					s1_reg[i] <= din[i];
					s2_reg[i] <= s1_reg[i];
					s3_reg[i] <= s2_reg[i];
					// A lone glitch in stage two cannot reach the output.
					if (s2_reg[i] == s3_reg[i]) begin
						dout[i] <= s3_reg[i];
					end
				end
			end
		end
	endgenerate

endmodule // epw_sync

`default_nettype wire

/* hw/epw_port.v */
// Eight-bit general-purpose port with per-pin wakeup input select.
`timescale 1ns/1ps
`default_nettype none
`include "epw_map.vh"

module epw_port #(
	parameter WIDTH = 8
) (
	input  wire                   CLOCK,
	input  wire                   SYS_RST,
	input  wire [`EPW_ADDR_W-1:0] ADDR,
	input  wire [`EPW_DATA_W-1:0] WDATA,
	input  wire                   WR_STB,
	input  wire                   RD_STB,
	output reg  [`EPW_DATA_W-1:0] RDATA,
	input  wire [`EPW_MODE_W-1:0] POWER_MODE,
	input  wire [WIDTH-1:0]       PIN_IN,
	output reg  [WIDTH-1:0]       PIN_OUT,
	output reg  [WIDTH-1:0]       PIN_OE,
	output reg  [WIDTH-1:0]       PULLUP_EN,
	output wire [WIDTH-1:0]       WAKEUP_IN
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------

	reg  [WIDTH-1:0]       port_data_latch_reg;
	reg  [WIDTH-1:0]       pin_direction_reg;
	reg  [WIDTH-1:0]       pullup_control_reg;
	reg  [WIDTH-1:0]       pin_function_select_reg;

	reg  [WIDTH-1:0]       port_data_latch_next;
	reg  [WIDTH-1:0]       pin_direction_next;
	reg  [WIDTH-1:0]       pullup_control_next;
	reg  [WIDTH-1:0]       pin_function_select_next;

	reg  [`EPW_DATA_W-1:0] rdata_next;
	wire [WIDTH-1:0]       pin_sampled;
	wire [WIDTH-1:0]       drive_sel;
	wire [WIDTH-1:0]       read_mix;

	wire                   sel_data;
	wire                   sel_dir;
	wire                   sel_pullup;
	wire                   sel_func;
	wire                   hold_mode;
	wire                   float_mode;

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------

	// Addresses are compared in full, so mirrors of a register never respond.
	function hit;
		input [`EPW_ADDR_W-1:0] a;
		input [`EPW_ADDR_W-1:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	// Sleep, subsleep and watch keep the pins as they were.
	function mode_holds;
		input [`EPW_MODE_W-1:0] m;
		begin
			case (m)
				`EPW_MODE_SLEEP, `EPW_MODE_SUBSLEEP, `EPW_MODE_WATCH: begin
					mode_holds = 1'b1;
				end
				default: begin
					mode_holds = 1'b0;
				end
			endcase
		end
	endfunction

	// Codes without a meaning of their own run the port as in active mode.
	function mode_floats;
		input [`EPW_MODE_W-1:0] m;
		begin
			case (m)
				`EPW_MODE_STANDBY: begin
					mode_floats = 1'b1;
				end
				default: begin
					mode_floats = 1'b0;
				end
			endcase
		end
	endfunction

	assign sel_data   = hit(ADDR, `EPW_ADDR_DATA);
	assign sel_dir    = hit(ADDR, `EPW_ADDR_DIR);
	assign sel_pullup = hit(ADDR, `EPW_ADDR_PULLUP);
	assign sel_func   = hit(ADDR, `EPW_ADDR_FUNC_SEL);
	assign hold_mode  = mode_holds(POWER_MODE);
	assign float_mode = mode_floats(POWER_MODE);

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------

	// Each register takes a write only at its own address; others are ignored.
	always @* begin
		port_data_latch_next = port_data_latch_reg;
		if (WR_STB && sel_data) begin
			port_data_latch_next = WDATA[WIDTH-1:0];
		end
	end

	always @* begin
		pin_direction_next = pin_direction_reg;
		if (WR_STB && sel_dir) begin
			pin_direction_next = WDATA[WIDTH-1:0];
		end
	end

	always @* begin
		pullup_control_next = pullup_control_reg;
		if (WR_STB && sel_pullup) begin
			pullup_control_next = WDATA[WIDTH-1:0];
		end
	end

	always @* begin
		pin_function_select_next = pin_function_select_reg;
		if (WR_STB && sel_func) begin
			pin_function_select_next = WDATA[WIDTH-1:0];
		end
	end

	always @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			port_data_latch_reg <= `EPW_RESET_VAL;
		end else begin
			port_data_latch_reg <= port_data_latch_next;
		end
	end

	always @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pin_direction_reg <= `EPW_RESET_VAL;
		end else begin
			pin_direction_reg <= pin_direction_next;
		end
	end

	always @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pullup_control_reg <= `EPW_RESET_VAL;
		end else begin
			pullup_control_reg <= pullup_control_next;
		end
	end

	always @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pin_function_select_reg <= `EPW_RESET_VAL;
		end else begin
			pin_function_select_reg <= pin_function_select_next;
		end
	end

	// Direction counts as output only for general I/O pins.
	assign drive_sel = pin_direction_reg & ~pin_function_select_reg;

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------

	// The raw direction bit chooses here, so a wakeup pin left with
	// direction one reads its latch rather than its level.
	genvar r;
	generate
		for (r = 0; r < WIDTH; r = r + 1) begin : g_read
			assign read_mix[r] = pin_direction_reg[r] ? port_data_latch_reg[r] :
			                     pin_sampled[r];
		end
	endgenerate

	always @* begin
		rdata_next = `EPW_UNMAPPED_VAL;
		if (sel_data) begin
			rdata_next = read_mix;
		end else if (sel_dir) begin
			rdata_next = `EPW_DIR_READ_VAL;
		end else if (sel_pullup) begin
			rdata_next = pullup_control_reg;
		end else if (sel_func) begin
			rdata_next = pin_function_select_reg;
		end
	end

	// Read data stand only in the cycle after the strobe, zero otherwise.
	always @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA <= `EPW_UNMAPPED_VAL;
		end else if (RD_STB) begin
			RDATA <= rdata_next;
		end else begin
			RDATA <= `EPW_UNMAPPED_VAL;
		end
	end

	// ------------------------------------------------------------------
	// Pin input synchroniser
	// ------------------------------------------------------------------

	epw_sync #(
		.WIDTH (WIDTH)
	) u_sync (
		.clk  (CLOCK),
		.rst  (SYS_RST),
		.din  (PIN_IN),
		.dout (pin_sampled)
	);

	// Wakeup logic sees the synchronised level of selected pins only.
	assign WAKEUP_IN = pin_sampled & pin_function_select_reg;

	// ------------------------------------------------------------------
	// Pin drivers by power mode
	// ------------------------------------------------------------------

	// Every pin is driven by its own copy of the same small slice. The
	// outputs are registered, so a mode change reaches the pins one edge
	// later; software must allow for that before it relies on the pins.
	genvar n;
	generate
		for (n = 0; n < WIDTH; n = n + 1) begin : g_pin
			reg out_next;
			reg oe_next;
			reg pull_next;

			always @* begin
				out_next  = port_data_latch_reg[n] & drive_sel[n];
				oe_next   = drive_sel[n];
				pull_next = pullup_control_reg[n] & ~drive_sel[n];
				if (hold_mode) begin
					// Freeze the drivers so register writes cannot disturb the pins.
					out_next  = PIN_OUT[n];
					oe_next   = PIN_OE[n];
					pull_next = PULLUP_EN[n];
				end else if (float_mode) begin
					out_next = `EPW_PIN_IDLE;
					oe_next  = `EPW_PIN_IDLE;
				end
			end

			// Reset floats every pin and turns every pull-up off.
			always @(posedge CLOCK or posedge SYS_RST) begin
				if (SYS_RST) begin
					PIN_OUT[n]   <= `EPW_PIN_IDLE;
					PIN_OE[n]    <= `EPW_PIN_IDLE;
					PULLUP_EN[n] <= `EPW_PIN_IDLE;
				end else begin
					PIN_OUT[n]   <= out_next;
					PIN_OE[n]    <= oe_next;
					PULLUP_EN[n] <= pull_next;
				end
			end
		end
	endgenerate

endmodule // epw_port

`default_nettype wire

/* verif/epw_port_props.sv */
// Concurrent checks bound to the eight-bit port.
`timescale 1ns/1ps
`default_nettype none
// ---
// Port checker
// ---
module epw_chk #(
	parameter WIDTH = 8
) (
	input wire logic             CLOCK,
	input wire logic             SYS_RST,
	input wire logic [15:0]      ADDR,
	input wire logic             RD_STB,
	input wire logic [7:0]       RDATA,
	input wire logic [2:0]       POWER_MODE,
	input wire logic [WIDTH-1:0] PIN_OUT,
	input wire logic [WIDTH-1:0] PIN_OE,
	input wire logic [WIDTH-1:0] PULLUP_EN,
	input wire logic [WIDTH-1:0] WAKEUP_IN
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	dir_read_a: assert property (
		$past(RD_STB) && $past(ADDR) == 16'hffe8 |-> RDATA == 8'hff) else $error("dir read");
	out_pullup_a: assert property (
		(PIN_OE & PULLUP_EN) == 0) else $error("pullup on output");
	undriven_out_a: assert property (
		(PIN_OUT & ~PIN_OE) == 0) else $error("undriven pin out");
	standby_float_a: assert property (
		$past(POWER_MODE) == 3'h3 |-> PIN_OE == 0) else $error("standby drive");
	standby_pull_a: assert property (
		$past(POWER_MODE, 2) == 3'h3 && $past(POWER_MODE) == 3'h3 |-> $stable(PULLUP_EN))
		else $error("standby pullup");
	sleep_hold_a: assert property (
		$past(POWER_MODE) == 3'h1 |-> $stable(PIN_OE) && $stable(PIN_OUT))
		else $error("sleep hold");
	wake_input_a: assert property (
		$past(POWER_MODE) == 0 |-> ($past(WAKEUP_IN, 2) & $past(WAKEUP_IN) & PIN_OE) == 0)
		else $error("wakeup pin driven");
	reset_float_a: assert property (
		$fell(SYS_RST) |-> PIN_OE == 0 && PULLUP_EN == 0) else $error("reset pins");
endmodule // epw_chk

bind epw_port epw_chk #(.WIDTH(WIDTH)) chk_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR),
	.RD_STB(RD_STB), .RDATA(RDATA), .POWER_MODE(POWER_MODE), .PIN_OUT(PIN_OUT),
	.PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN), .WAKEUP_IN(WAKEUP_IN));
`default_nettype wire

/* verif/tb_top.sv */
// Register and pin scenarios for the eight-bit port.
`timescale 1ns/1ps
`default_nettype none
// ---
// Bench
// ---
module tb_top;
	logic       clock = 0, sys_rst = 1, wr = 0, rd = 0;
	logic [15:0] addr = 0;
	logic [7:0] wdata = 0, rdata, pin_in = 0, pin_out, pin_oe, pullup_en, wake;
	logic [2:0] mode = 0;
	int         n_mismatch = 0, num_checks = 0;
	epw_port dut (.CLOCK(clock), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
		.WR_STB(wr), .RD_STB(rd), .RDATA(rdata), .POWER_MODE(mode), .PIN_IN(pin_in),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_EN(pullup_en), .WAKEUP_IN(wake));
	initial forever #50 clock = ~clock;
	task automatic chk(input string what, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(what, rdata, exp);
	endtask
	// Pin paths pass a synchroniser, so let them settle before looking.
	task automatic settle;
		repeat (6) @(posedge clock);
		#1;
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		rd_reg(16'hffd8, 8'h00, "data");
		rd_reg(16'hffe8, 8'hff, "dir");
		rd_reg(16'hff9e, 8'h00, "pullup");
		pin_in <= 8'ha5;
		wr_reg(16'hff9e, 8'hff);
		wr_reg(16'hffe8, 8'h0f);
		wr_reg(16'hffd8, 8'h3c);
		settle();
		chk("oe", pin_oe, 8'h0f);
		chk("out", pin_out, 8'h0c);
		chk("pull", pullup_en, 8'hf0);
		rd_reg(16'hffd8, 8'hac, "data");
		rd_reg(16'hffe8, 8'hff, "dir");
		rd_reg(16'h0000, 8'h00, "unmapped");
		wr_reg(16'hff9b, 8'h03);
		settle();
		chk("oe", pin_oe, 8'h0c);
		chk("wake", wake, 8'h01);
		wr_reg(16'h0000, 8'hff);
		rd_reg(16'hff9b, 8'h03, "func");
		mode <= 3'h3;
		settle();
		chk("oe", pin_oe, 8'h00);
		chk("pull", pullup_en, 8'hf3);
		mode <= 3'h1;
		wr_reg(16'hffe8, 8'hff);
		settle();
		chk("oe", pin_oe, 8'h00);
		chk("pull", pullup_en, 8'hf3);
		mode <= 3'h5;
		settle();
		chk("oe", pin_oe, 8'hfc);
		mode <= 3'h2;
		wr_reg(16'hffe8, 8'h00);
		settle();
		chk("oe", pin_oe, 8'hfc);
		mode <= 3'h4;
		settle();
		chk("oe", pin_oe, 8'hfc);
		chk("pull", pullup_en, 8'h03);
		mode <= 3'h5;
		wr_reg(16'hffe8, 8'hff);
		settle();
		chk("oe", pin_oe, 8'hfc);
		sys_rst <= 1'b1;
		settle();
		chk("oe", pin_oe, 8'h00);
		sys_rst <= 1'b0;
		rd_reg(16'hff9b, 8'h00, "func");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
